// ===== hdl/scr_pkg.sv
// constants and carrier types for the sensor setup and calibration registers
package scr_pkg;

  // ********************************
  // register byte addresses
  // ********************************
  localparam logic [7:0] ACCESS_CTRL_ADDR = 8'h08;
  localparam logic [7:0] CONV_SETUP_ADDR = 8'h0A;
  localparam logic [7:0] PRESSURE_LIN_ADDR = 8'h22;
  localparam logic [7:0] PRESSURE_OFFSET_ADDR = 8'h24;
  localparam logic [7:0] PRESSURE_TEMP_ADDR = 8'h26;
  localparam logic [7:0] TEMP_SENSOR_LIN_ADDR = 8'h2C;
  localparam logic [7:0] TEMP_SENSOR_OFFSET_ADDR = 8'h32;
  localparam logic [7:0] COEF_EXT_ADDR = 8'h34;
  localparam logic [7:0] CAL_FIRST_ADDR = 8'h20;
  localparam logic [7:0] CAL_LAST_ADDR = 8'h35;
  localparam int CAL_WORDS = 11;

  // ********************************
  // fields and reset values
  // ********************************
  localparam int READ_DIS_BIT = 6;
  localparam logic [7:0] ACCESS_CTRL_FIXED = 8'h25;
  localparam logic READ_DIS_RST = 1'b1;
  localparam logic [1:0] SETUP_RST = 2'h2;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] CAL_BLOCKED_READ = 8'h00;
  localparam int EXT_PRESSURE_LSB = 8;
  localparam int EXT_TEMP_LSB = 0;

  typedef struct packed {
    logic [1:0] conv_power_up;
    logic calibration_read_disable;
  } scr_cfg_t;

  typedef struct packed {
    logic [23:0] pressure_offset_coeff;
    logic [23:0] temp_sensor_offset_coeff;
  } scr_coef_t;

  typedef enum logic [3:0] {
    SCR_IDLE,
    SCR_DEV,
    SCR_DEV_ACK,
    SCR_PTR,
    SCR_PTR_ACK,
    SCR_WDATA,
    SCR_WDATA_ACK,
    SCR_RDATA,
    SCR_RDATA_ACK
  } scr_state_t;

endpackage

// ===== hdl/scr_regs.sv
// i2c target holding converter setup, calibration access and calibration words
module scr_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h56
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [scr_pkg::CAL_WORDS-1:0][15:0] otp_words,
  output scr_pkg::scr_cfg_t cfg,
  output scr_pkg::scr_coef_t coef
);

  // ********************************
  // pin synchronisers and edges
  // ********************************
  logic scl_q1_r, scl_q2_r, scl_q3_r;
  logic sda_q1_r, sda_q2_r, sda_q3_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q1_r <= 1'b1;
      scl_q2_r <= 1'b1;
      scl_q3_r <= 1'b1;
      sda_q1_r <= 1'b1;
      sda_q2_r <= 1'b1;
      sda_q3_r <= 1'b1;
    end else begin
      scl_q1_r <= scl_i;
      scl_q2_r <= scl_q1_r;
      scl_q3_r <= scl_q2_r;
      sda_q1_r <= sda_i;
      sda_q2_r <= sda_q1_r;
      sda_q3_r <= sda_q2_r;
    end
  end

  wire scl_rise = scl_q2_r & ~scl_q3_r;
  wire scl_fall = ~scl_q2_r & scl_q3_r;
  wire bus_start = scl_q2_r & scl_q3_r & sda_q3_r & ~sda_q2_r;
  wire bus_stop = scl_q2_r & scl_q3_r & ~sda_q3_r & sda_q2_r;

  // ********************************
  // registers and transfer state
  // ********************************
  scr_pkg::scr_state_t state_r, state_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic rw_r, rw_nxt;
  logic oe_r, oe_nxt;
  logic [1:0] setup_r, setup_nxt;
  logic read_dis_r, read_dis_nxt;
  scr_pkg::scr_coef_t coef_r;

  // ********************************
  // read data selection
  // ********************************
  wire in_cal = (ptr_r >= scr_pkg::CAL_FIRST_ADDR) &&
                (ptr_r <= scr_pkg::CAL_LAST_ADDR);
  wire [3:0] cal_idx = ptr_r[4:1];
  wire [15:0] cal_word = otp_words[cal_idx];
  wire [7:0] cal_byte = ptr_r[0] ? cal_word[7:0] : cal_word[15:8];
  wire [7:0] access_byte = scr_pkg::ACCESS_CTRL_FIXED |
                           {1'b0, read_dis_r, 6'h00};
  wire [7:0] setup_byte = {6'h00, setup_r};
  wire [7:0] read_byte;
  assign read_byte = (ptr_r == scr_pkg::ACCESS_CTRL_ADDR) ? access_byte :
                     (ptr_r == scr_pkg::CONV_SETUP_ADDR) ? setup_byte :
                     (in_cal && read_dis_r) ? scr_pkg::CAL_BLOCKED_READ :
                     in_cal ? cal_byte :
                     scr_pkg::UNMAPPED_READ;

  wire wr_access = ptr_r == scr_pkg::ACCESS_CTRL_ADDR;
  wire wr_setup = ptr_r == scr_pkg::CONV_SETUP_ADDR;
  wire dev_match = shift_r[7:1] == DEV_ADDR;

  // ********************************
  // protocol engine
  // ********************************
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    oe_nxt = oe_r;
    setup_nxt = setup_r;
    read_dis_nxt = read_dis_r;
    if (bus_stop) begin
      state_nxt = scr_pkg::SCR_IDLE;
      oe_nxt = 1'b0;
    end else if (bus_start) begin
      state_nxt = scr_pkg::SCR_DEV;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (scl_rise) begin
      case (state_r)
        scr_pkg::SCR_DEV, scr_pkg::SCR_PTR, scr_pkg::SCR_WDATA: begin
          shift_nxt = {shift_r[6:0], sda_q2_r};
          cnt_nxt = cnt_r + 4'h1;
        end
        scr_pkg::SCR_RDATA: begin
          cnt_nxt = cnt_r + 4'h1;
        end
        scr_pkg::SCR_RDATA_ACK: begin
          if (sda_q2_r) begin
            state_nxt = scr_pkg::SCR_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state_r)
        scr_pkg::SCR_DEV: begin
          if (cnt_r == 4'h8) begin
            if (dev_match) begin
              rw_nxt = shift_r[0];
              oe_nxt = 1'b1;
              state_nxt = scr_pkg::SCR_DEV_ACK;
            end else begin
              state_nxt = scr_pkg::SCR_IDLE;
            end
          end
        end
        scr_pkg::SCR_DEV_ACK, scr_pkg::SCR_RDATA_ACK: begin
          cnt_nxt = 4'h0;
          if (rw_r) begin
            shift_nxt = {read_byte[6:0], 1'b0};
            oe_nxt = ~read_byte[7];
            state_nxt = scr_pkg::SCR_RDATA;
          end else begin
            oe_nxt = 1'b0;
            state_nxt = scr_pkg::SCR_PTR;
          end
        end
        scr_pkg::SCR_PTR: begin
          if (cnt_r == 4'h8) begin
            ptr_nxt = shift_r;
            oe_nxt = 1'b1;
            state_nxt = scr_pkg::SCR_PTR_ACK;
          end
        end
        scr_pkg::SCR_PTR_ACK, scr_pkg::SCR_WDATA_ACK: begin
          cnt_nxt = 4'h0;
          oe_nxt = 1'b0;
          state_nxt = scr_pkg::SCR_WDATA;
        end
        scr_pkg::SCR_WDATA: begin
          if (cnt_r == 4'h8) begin
            // calibration and unmapped addresses take no write
            if (wr_access) begin
              read_dis_nxt = shift_r[scr_pkg::READ_DIS_BIT];
            end else if (wr_setup) begin
              setup_nxt = shift_r[1:0];
            end
            ptr_nxt = ptr_r + 8'h01;
            oe_nxt = 1'b1;
            state_nxt = scr_pkg::SCR_WDATA_ACK;
          end
        end
        scr_pkg::SCR_RDATA: begin
          if (cnt_r == 4'h8) begin
            oe_nxt = 1'b0;
            ptr_nxt = ptr_r + 8'h01;
            state_nxt = scr_pkg::SCR_RDATA_ACK;
          end else begin
            oe_nxt = ~shift_r[7];
            shift_nxt = {shift_r[6:0], 1'b0};
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= scr_pkg::SCR_IDLE;
      shift_r <= 8'h00;
      cnt_r <= 4'h0;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      oe_r <= 1'b0;
      setup_r <= scr_pkg::SETUP_RST;
      read_dis_r <= scr_pkg::READ_DIS_RST;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      oe_r <= oe_nxt;
      setup_r <= setup_nxt;
      read_dis_r <= read_dis_nxt;
    end
  end

  // ********************************
  // assembled 24-bit offsets
  // ********************************
  localparam int PR_OFS_IDX = int'((scr_pkg::PRESSURE_OFFSET_ADDR -
                                    scr_pkg::CAL_FIRST_ADDR) >> 1);
  localparam int TS_OFS_IDX = int'((scr_pkg::TEMP_SENSOR_OFFSET_ADDR -
                                    scr_pkg::CAL_FIRST_ADDR) >> 1);
  localparam int EXT_IDX = int'((scr_pkg::COEF_EXT_ADDR -
                                 scr_pkg::CAL_FIRST_ADDR) >> 1);
  wire [15:0] ext_word = otp_words[EXT_IDX];
  wire [7:0] ext_pr = ext_word[scr_pkg::EXT_PRESSURE_LSB +: 8];
  wire [7:0] ext_ts = ext_word[scr_pkg::EXT_TEMP_LSB +: 8];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      coef_r <= '0;
    end else begin
      coef_r.pressure_offset_coeff <= {ext_pr, otp_words[PR_OFS_IDX]};
      coef_r.temp_sensor_offset_coeff <= {ext_ts, otp_words[TS_OFS_IDX]};
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = oe_r;
  assign cfg.conv_power_up = setup_r;
  assign cfg.calibration_read_disable = read_dis_r;
  assign coef = coef_r;

endmodule

// ===== test/scr_host.sv
// i2c host model driving the register target pins
module scr_host (
  input wire logic core_clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_q = 1'b1;
  initial scl = 1'b1;
  // open drain data line with pull-up
  assign sda = sda_q & !sda_oe;
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_q = b;
    wt(4);
    scl = 1'b1;
    wt(4);
    r = sda;
    wt(4);
    scl = 1'b0;
    wt(4);
  endtask
  task automatic start();
    sda_q = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(4);
    sda_q = 1'b0;
    wt(4);
    scl = 1'b0;
    wt(4);
  endtask
  task automatic stop();
    sda_q = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(4);
    sda_q = 1'b1;
    wt(4);
  endtask
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, ack);
  endtask
endmodule

// ===== test/scr_regs_properties.sv
// assertions and covers on the register target ports
module scr_regs_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_oe,
  input wire logic [scr_pkg::CAL_WORDS-1:0][15:0] otp_words,
  input wire scr_pkg::scr_cfg_t cfg,
  input wire scr_pkg::scr_coef_t coef
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [23:0] po = coef.pressure_offset_coeff;
  wire [23:0] to = coef.temp_sensor_offset_coeff;
  wire [15:0] ex = otp_words[10];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_pext; $past(rst_n) |-> po[23:16] == ex[15:8]; endproperty
  a_pext: assert property (p_pext) else $error("pressure ext bad");
  property p_text; $past(rst_n) |-> to[23:16] == ex[7:0]; endproperty
  a_text: assert property (p_text) else $error("temp ext bad");
  property p_low;
    $past(rst_n) |-> po[15:0] == otp_words[2] && to[15:0] == otp_words[9];
  endproperty
  a_low: assert property (p_low) else $error("offset low bad");
  property p_rpu; $rose(rst_n) |-> cfg.conv_power_up == 2'h2; endproperty
  a_rpu: assert property (p_rpu) else $error("setup reset bad");
  property p_rdis; $rose(rst_n) |-> cfg.calibration_read_disable; endproperty
  a_rdis: assert property (p_rdis) else $error("disable reset bad");
  property p_cfg; $changed(cfg) |-> !scl_i && !$past(scl_i); endproperty
  a_cfg: assert property (p_cfg) else $error("cfg moved early");
  property p_oe; $changed(sda_oe) |-> !scl_i; endproperty
  a_oe: assert property (p_oe) else $error("sda moved scl high");
  property p_oerst; $rose(rst_n) |-> !sda_oe; endproperty
  a_oerst: assert property (p_oerst) else $error("sda driven");
  c_en: cover property ($fell(cfg.calibration_read_disable));
  c_ack: cover property ($rose(sda_oe));
  c_rst: cover property ($rose(rst_n));
endmodule

bind scr_regs scr_regs_properties i_scr_regs_properties (
  .core_clk(core_clk), .rst_n(rst_n), .scl_i(scl_i), .sda_oe(sda_oe),
  .otp_words(otp_words), .cfg(cfg), .coef(coef));

// ===== test/testbench.sv
// self-checking bench for the setup and calibration registers
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV = 7'h56;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sda, sda_o, sda_oe, ak;
  logic [scr_pkg::CAL_WORDS-1:0][15:0] otp_words;
  scr_pkg::scr_cfg_t cfg;
  scr_pkg::scr_coef_t coef;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  logic [15:0] rv;
  logic [7:0] a;
  always #20 core_clk = !core_clk;
  scr_regs #(.DEV_ADDR(DEV)) i_scr_regs (.core_clk(core_clk), .rst_n(rst_n),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .otp_words(otp_words), .cfg(cfg), .coef(coef));
  scr_host i_scr_host (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl),
    .sda(sda));
  function automatic logic [15:0] cal_exp(input int i, input logic en);
    return en ? otp_words[i] : 16'h0000;
  endfunction
  // 24-bit offset: extension byte from the last word over the low word
  function automatic logic [23:0] ofs_exp(input int lo, input logic hi);
    logic [15:0] ext;
    ext = otp_words[10];
    return {hi ? ext[15:8] : ext[7:0], otp_words[lo]};
  endfunction
  task automatic chk(string n, logic [23:0] s, logic [23:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic go(logic [7:0] p, logic [7:0] d, logic w,
                    output logic [15:0] v);
    logic [7:0] q;
    logic nak;
    i_scr_host.start();
    i_scr_host.xfer({DEV, 1'b0}, 1'b1, q, ak);
    nak = ak;
    i_scr_host.xfer(p, 1'b1, q, ak);
    nak = nak | ak;
    if (w) begin
      i_scr_host.xfer(d, 1'b1, q, ak);
      nak = nak | ak;
    end else begin
      i_scr_host.start();
      i_scr_host.xfer({DEV, 1'b1}, 1'b1, q, ak);
      nak = nak | ak;
      i_scr_host.xfer(8'hFF, 1'b0, v[15:8], ak);
      i_scr_host.xfer(8'hFF, 1'b1, v[7:0], ak);
    end
    i_scr_host.stop();
    chk("ack", nak, 1'b0);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(83));
    for (int i = 0; i < scr_pkg::CAL_WORDS; i++) otp_words[i] = 16'($urandom);
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    chk("power_up", cfg.conv_power_up, 2'h2);
    chk("sda_o", sda_o, 1'b0);
    chk("p_off", coef.pressure_offset_coeff, ofs_exp(2, 1'b1));
    chk("t_off", coef.temp_sensor_offset_coeff, ofs_exp(9, 1'b0));
    go(8'h08, 8'h00, 1'b0, rv);
    chk("access", rv, 16'h6500);
    go(8'h0A, 8'h00, 1'b0, rv);
    chk("setup", rv[15:8], 8'h02);
    go(8'h22, 8'h00, 1'b0, rv);
    chk("blocked", rv, cal_exp(1, 1'b0));
    go(8'h08, 8'h25, 1'b1, rv);
    chk("read_dis", cfg.calibration_read_disable, 1'b0);
    go(8'h0A, 8'h02, 1'b1, rv);
    chk("power_up", cfg.conv_power_up, 2'h2);
    for (int i = 0; i < scr_pkg::CAL_WORDS; i++) begin
      go(8'h20 + 8'(2 * i), 8'h00, 1'b0, rv);
      chk("cal", rv, cal_exp(i, 1'b1));
    end
    for (int k = 0; k < 3; k++) begin
      a = 8'($urandom_range(0, 10));
      go(8'h20 + 8'(2 * a), 8'($urandom), 1'b1, rv);
      go(8'h20 + 8'(2 * a), 8'h00, 1'b0, rv);
      chk("cal_wr", rv, cal_exp(a, 1'b1));
    end
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("read_dis", cfg.calibration_read_disable, 1'b1);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    go(8'h34, 8'h00, 1'b0, rv);
    chk("blocked", rv, cal_exp(10, 1'b0));
    print_verdict();
  end
endmodule
